//--- tb/wrb_chk.sv
// port checks for the wake, reset and boot sequencer
module wrb_chk (
    input wire logic       core_clk,              // clock
    input wire logic       rst_b,                 // reset pin
    input wire logic       supply_above_low,      // low threshold
    input wire logic       ext_irq_zero_pin,      // wake pin
    input wire logic       irq_zero_wake_enable,  // wake enable
    input wire logic       pd_bit,                // power-down bit
    input wire logic       pd_instr,              // entry pulse
    input wire logic       return_from_interrupt, // handler end
    input wire logic       core_reset_q,          // core reset
    input wire logic [1:0] boot_mode_q,           // boot mode
    input wire logic       emu_enable_q,          // emulation on
    input wire logic       core_clk_en_q,         // clock gate
    input wire logic       synth_en_q,            // synth on
    input wire logic       pin_hold_q,            // pins frozen
    input wire logic       irq_zero_service_q,    // handler request
    input wire logic       resume_load_q          // resume pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    chk_pd_entry: assert property (
        pd_instr && pd_bit && core_clk_en_q && !irq_zero_service_q && !core_reset_q
        |=> !core_clk_en_q && !synth_en_q && pin_hold_q) else $error("bad entry");
    chk_no_wake: assert property (
        pin_hold_q && !irq_zero_wake_enable |=> pin_hold_q) else $error("woke while off");
    chk_wake_time: assert property (
        pin_hold_q && irq_zero_wake_enable && !ext_irq_zero_pin
        |-> ##[1:6] irq_zero_service_q && core_clk_en_q) else $error("slow wake");
    chk_wake_clocks: assert property (
        $rose(irq_zero_service_q) |-> core_clk_en_q && synth_en_q && !pin_hold_q)
        else $error("clocks off in handler");
    chk_return: assert property (
        irq_zero_service_q && return_from_interrupt |=> resume_load_q && !irq_zero_service_q)
        else $error("no resume");
    chk_resume_pulse: assert property (
        resume_load_q |=> !resume_load_q) else $error("long resume pulse");
    chk_brownout: assert property (
        !supply_above_low |-> ##[0:4] core_reset_q) else $error("no reset on low supply");
    chk_boot_emu: assert property (
        !core_reset_q |-> !boot_mode_q[1] && emu_enable_q == boot_mode_q[0])
        else $error("bad boot mode");
endmodule
bind wrb_sequencer wrb_chk chk (.*);

//--- tb/wrb_far.sv
// interrupt source model for pin zero
module wrb_far (
    input  wire logic core_clk,           // clock
    input  wire logic pd_instr,           // mode entry seen
    input  wire logic wake_req,           // bench asks for wake
    input  wire logic irq_zero_service_q, // handler running
    output logic      ext_irq_zero_pin    // active low pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] guard_q = 5'h00;
    initial ext_irq_zero_pin = 1'b1;
    // two machine cycles of 12 clocks kept quiet after entry, so a fast wake waits
    always @(posedge core_clk) begin
        guard_q <= pd_instr ? 5'h18 : guard_q - {4'h0, guard_q != 5'h00};
        if (irq_zero_service_q || !wake_req)
            ext_irq_zero_pin <= 1'b1;
        else if (guard_q == 5'h00 && !pd_instr)
            ext_irq_zero_pin <= 1'b0;
    end
endmodule

//--- tb/wrb_sequencer_tb.sv
// testbench for the wake, reset and boot sequencer
`include "wrb_map.vh"
module wrb_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 0, rst_b = 0, supply_above_por = 0, supply_above_low = 0;
    logic        boot_select_pin = 0, pd_bit = 0, idle_bit = 0, irq_zero_wake_enable = 0;
    logic        pd_instr = 0, return_from_interrupt = 0, wake_req = 0, ext_irq_zero_pin;
    logic [15:0] next_pc = 16'h0000, resume_pc_q;
    logic [1:0]  boot_mode_q;
    logic        core_reset_q, emu_enable_q, core_clk_en_q, synth_en_q, pin_hold_q;
    logic        irq_zero_service_q, resume_load_q;
    int          fail_count = 0, comparisons = 0, n;
    always #20 core_clk = ~core_clk;
    // short count keeps the reset wait to a few cycles
    wrb_sequencer #(.POR_CYCLES(10)) dut (.*);
    wrb_far far (.*);
    ////////////////////////////////////////
    task tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wait_release;
        n = 0;
        while (core_reset_q !== 1'b0 && n < 40) begin
            tick(1);
            n++;
        end
    endtask
    task do_reset(input logic strap);
        rst_b = 0;
        supply_above_por = 0;
        supply_above_low = 1;
        boot_select_pin = strap;
        tick(10);
        rst_b = 1;
        supply_above_por = 1;
        wait_release();
        check("por_delay", 1, n >= 10 && n < 20);
        check("boot_mode", strap ? `WRB_MODE_DOWNLOAD : `WRB_MODE_NORMAL, boot_mode_q);
        check("emu_enable", strap, emu_enable_q);
        $display("test reset done");
    endtask
    task sleep_wake(input logic enable);
        irq_zero_wake_enable = enable;
        pd_bit = 1;
        next_pc = 16'h1F2E;
        pd_instr = 1;
        tick(1);
        pd_instr = 0;
        check("clk_en", 0, core_clk_en_q);
        check("pin_hold", 1, pin_hold_q);
        check("synth_en", 0, synth_en_q);
        wake_req = 1;
        n = 0;
        while (irq_zero_service_q !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        check("service", enable, irq_zero_service_q);
        check("clk_en", enable, core_clk_en_q);
        check("synth_en", enable, synth_en_q);
        check("pin_hold", !enable, pin_hold_q);
        wake_req = 0;
        pd_bit = 0;
        return_from_interrupt = enable;
        tick(1);
        return_from_interrupt = 0;
        check("resume_load", enable, resume_load_q);
        check("resume_pc", 16'h1F2E, resume_pc_q);
        $display("test sleep done");
    endtask
    // idle stops only the core clock; pin zero brings it back
    task idle_wake;
        idle_bit = 1;
        pd_instr = 1;
        tick(1);
        pd_instr = 0;
        check("clk_en", 0, core_clk_en_q);
        check("pin_hold", 0, pin_hold_q);
        check("synth_en", 1, synth_en_q);
        wake_req = 1;
        n = 0;
        while (core_clk_en_q !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        check("clk_en", 1, core_clk_en_q);
        wake_req = 0;
        idle_bit = 0;
        tick(2);
        $display("test idle done");
    endtask
    // supply between thresholds must not reset an armed part
    task brownout;
        supply_above_por = 0;
        tick(5);
        check("core_reset", 0, core_reset_q);
        supply_above_low = 0;
        tick(4);
        check("core_reset", 1, core_reset_q);
        supply_above_low = 1;
        supply_above_por = 1;
        wait_release();
        check("core_reset", 0, core_reset_q);
        $display("test brownout done");
    endtask
    task print_verdict;
        $display("%0d mismatches in %0d comparisons", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        do_reset(1);
        sleep_wake(1);
        idle_wake();
        brownout();
        do_reset(0);
        sleep_wake(0);
        print_verdict();
    end
    initial begin
        #60000;
        fail_count++;
        print_verdict();
    end
endmodule

//--- verilog/wrb_map.vh
// constants for the wake, reset and boot sequencer
`ifndef WRB_MAP_VH
`define WRB_MAP_VH
`define WRB_CLK_HZ        25000000
`define WRB_POR_DELAY_MS  128
`define WRB_POR_CYCLES    (`WRB_CLK_HZ / 1000 * `WRB_POR_DELAY_MS)
`define WRB_MODE_NORMAL   2'h0
`define WRB_MODE_DOWNLOAD 2'h1
`define WRB_MODE_EMULATE  2'h2
`define WRB_ST_RESET      3'h0
`define WRB_ST_RUN        3'h1
`define WRB_ST_IDLE       3'h2
`define WRB_ST_DOWN       3'h3
`define WRB_ST_WAKE       3'h4
`define WRB_ST_ISR        3'h5
`endif

//--- verilog/wrb_sequencer.v
// wake from power-down, power-on reset timing and boot strap capture
`include "wrb_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - pin zero low wakes power-down, runs handler
// - handler return resumes after power-down instruction
// - wake only if wake enable was set
// - hold reset while low, then 128 ms
// - once out of reset, stay out until supply below low threshold
// - strap high at reset end: download mode
// - strap low at reset end: normal run
// - debug entry shares the download sequence
// - emulation controller reached through strap pin
// - power-down bit and idle bit select modes
// - power-down stops synth and core clock, pins hold
module wrb_sequencer #(
    parameter POR_CYCLES = `WRB_POR_CYCLES
) (
    input  wire       core_clk,             // always-running oscillator-derived clock
    input  wire       rst_b,                // external reset pin, active low
    input  wire       supply_above_por,     // comparator: supply over power-on threshold
    input  wire       supply_above_low,     // comparator: supply over lower release threshold
    input  wire       ext_irq_zero_pin,     // external interrupt pin zero, active low
    input  wire       boot_select_pin,      // boot strap / emulator pin
    input  wire       pd_bit,               // power-down bit of power_control_reg
    input  wire       idle_bit,             // idle bit of power_control_reg
    input  wire       irq_zero_wake_enable, // wake enable bit of power_control_reg
    input  wire       pd_instr,             // pulse: instruction setting a mode retires
    input  wire [15:0] next_pc,             // address after the mode-entry instruction
    input  wire       return_from_interrupt,// pulse: handler returns
    output reg        core_reset_q,         // reset to core, active high
    output reg  [1:0] boot_mode_q,          // captured boot mode
    output reg        emu_enable_q,         // single-pin emulation controller enabled
    output reg        core_clk_en_q,        // gate for core clock
    output reg        synth_en_q,           // frequency synthesizer enable
    output reg        pin_hold_q,           // freeze port pin levels
    output reg        irq_zero_service_q,   // request to service pin zero handler
    output reg [15:0] resume_pc_q,          // address loaded at handler return
    output reg        resume_load_q         // pulse: load resume_pc_q
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisers
    reg       rst_s1_q;
    reg       rst_s2_q;
    reg [1:0] por_s_q;
    reg [1:0] low_s_q;
    reg [1:0] irq_s_q;
    reg [1:0] boot_s_q;

    // reset released through two flops so every flop leaves reset together
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // pins are asynchronous to core_clk; only the second flop is read
    always @(posedge core_clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            por_s_q  <= 2'h0;
            low_s_q  <= 2'h0;
            irq_s_q  <= 2'h3;
            boot_s_q <= 2'h0;
        end else begin
            por_s_q  <= {por_s_q[0], supply_above_por};
            low_s_q  <= {low_s_q[0], supply_above_low};
            irq_s_q  <= {irq_s_q[0], ext_irq_zero_pin};
            boot_s_q <= {boot_s_q[0], boot_select_pin};
        end
    end

    wire por_ok  = por_s_q[1];
    wire low_ok  = low_s_q[1];
    wire irq_low = ~irq_s_q[1];
    wire boot_hi = boot_s_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // power-on reset: arm above threshold, disarm only below the low threshold
    //
    // the two comparator inputs form a hysteresis band. the count only runs
    // while the supply sits above the power-on threshold, and any dip below
    // that threshold before arming starts the count again from zero, so a
    // slowly rising or bouncing supply never releases the core early.
    // once armed, only the lower threshold can pull the core back into
    // reset; a supply that sags into the band keeps running.
    // limitation: the count runs on core_clk, so the delay scales with the
    // oscillator; POR_CYCLES must be set for the clock actually fitted.
    reg        por_armed_q;
    reg [31:0] por_cnt_q;
    wire       por_done = (por_cnt_q >= POR_CYCLES - 1);

    // hysteresis: once running, a dip to between thresholds keeps us out of reset
    always @(posedge core_clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            por_armed_q <= 1'b0;
            por_cnt_q   <= 32'h0;
        end else if (!low_ok) begin
            por_armed_q <= 1'b0;
            por_cnt_q   <= 32'h0;
        end else if (!por_armed_q) begin
            if (por_ok) begin
                if (por_done)
                    por_armed_q <= 1'b1;
                else
                    por_cnt_q <= por_cnt_q + 32'h1;
            end else begin
                por_cnt_q <= 32'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power state machine
    //
    // flow: reset -> run; run -> down on the power-down bit, run -> idle on
    // the idle bit, power-down winning when both are set. down -> wake on a
    // synchronised low on pin zero, but only with the wake enable set.
    // wake restarts the synthesizer first and the core clock one edge
    // later, so the handler never starts on a clock that is still settling.
    // isr holds the service request until the handler returns, then pulses
    // resume_load_q so the core reloads the address after the entry
    // instruction.
    // hazard: a pin that is already low while the entry instruction retires
    // would wake at once; the far side is required to keep it high then.
    // limitation: the wake path is clocked, so the oscillator feeding
    // core_clk must stay up in power-down; only the gated copy stops.
    // trade-off: one extra edge of wake latency buys a clean clock restart.
    //
    // outputs are all registered here, so the core sees no glitch on the
    // clock gate or on its reset when the state changes.
    reg [2:0] state_q;

    // the strap is sampled in the cycle reset ends, never under async reset
    always @(posedge core_clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            state_q            <= `WRB_ST_RESET;
            core_reset_q       <= 1'b1;
            boot_mode_q        <= `WRB_MODE_NORMAL;
            emu_enable_q       <= 1'b0;
            core_clk_en_q      <= 1'b0;
            synth_en_q         <= 1'b0;
            pin_hold_q         <= 1'b0;
            irq_zero_service_q <= 1'b0;
            resume_pc_q        <= 16'h0000;
            resume_load_q      <= 1'b0;
        end else begin
            resume_load_q <= 1'b0;
            if (!por_armed_q) begin
                state_q       <= `WRB_ST_RESET;
                core_reset_q  <= 1'b1;
                core_clk_en_q <= 1'b0;
                synth_en_q    <= 1'b0;
                pin_hold_q    <= 1'b0;
                irq_zero_service_q <= 1'b0;
            end else begin
                case (state_q)
                    `WRB_ST_RESET: begin
                        core_reset_q  <= 1'b0;
                        core_clk_en_q <= 1'b1;
                        synth_en_q    <= 1'b1;
                        // download and debug are the same entry
                        boot_mode_q   <= boot_hi ? `WRB_MODE_DOWNLOAD
                                                 : `WRB_MODE_NORMAL;
                        emu_enable_q  <= boot_hi;
                        state_q       <= `WRB_ST_RUN;
                    end
                    `WRB_ST_RUN: begin
                        if (pd_instr && pd_bit) begin
                            // clocks stop; the wake path runs on core_clk, which stays up
                            resume_pc_q   <= next_pc;
                            core_clk_en_q <= 1'b0;
                            synth_en_q    <= 1'b0;
                            pin_hold_q    <= 1'b1;
                            state_q       <= `WRB_ST_DOWN;
                        end else if (pd_instr && idle_bit) begin
                            core_clk_en_q <= 1'b0;
                            state_q       <= `WRB_ST_IDLE;
                        end
                    end
                    `WRB_ST_IDLE: begin
                        // idle leaves on pin zero regardless of the power-down enable
                        if (irq_low) begin
                            core_clk_en_q <= 1'b1;
                            state_q       <= `WRB_ST_RUN;
                        end
                    end
                    `WRB_ST_DOWN: begin
                        // relies on the source keeping the pin high around entry
                        if (irq_low && irq_zero_wake_enable) begin
                            synth_en_q <= 1'b1;
                            state_q    <= `WRB_ST_WAKE;
                        end
                    end
                    `WRB_ST_WAKE: begin
                        // core clock restarts on the same edge the handler is requested; the synthesizer one edge earlier
                        core_clk_en_q      <= 1'b1;
                        pin_hold_q         <= 1'b0;
                        irq_zero_service_q <= 1'b1;
                        state_q            <= `WRB_ST_ISR;
                    end
                    `WRB_ST_ISR: begin
                        if (return_from_interrupt) begin
                            irq_zero_service_q <= 1'b0;
                            resume_load_q      <= 1'b1;
                            state_q            <= `WRB_ST_RUN;
                        end
                    end
                    default: state_q <= `WRB_ST_RESET;
                endcase
            end
        end
    end

endmodule
